// [rtl/sdadc_cfg.svh]
// Constants for the sigma-delta converter back end.
// Included by the decimator, the back end and the bench.
`ifndef SDADC_CFG_SVH
`define SDADC_CFG_SVH
`define WORD_MIN     8'h03
`define WORD_RST     8'h45
`define DEC_SHIFT    3
`define SETTLE_CONV  2'h3
`define MID_CODE     24'h800000
`define SAT_CODE     24'hFFFFFF
`define RAW_SHIFT    10
`define UNITY_RANGE  3'h0
`define A_MODE       4'h0
`define A_CFG        4'h1
`define A_CHAN       4'h2
`define A_WORD       4'h3
`define A_STAT       4'h4
`define A_MASK       4'h5
`define A_DATA0      4'h6
`define A_DATA1      4'h7
`define A_DATA2      4'h8
`define A_OFS0       4'h9
`define A_OFS1       4'hA
`define A_OFS2       4'hB
`define A_GAIN0      4'hC
`define A_GAIN1      4'hD
`define A_GAIN2      4'hE
`define MD_OFF       3'h0
`define MD_IDLE      3'h1
`define MD_SINGLE    3'h2
`define MD_CONT      3'h3
`define MD_IZERO     3'h4
`define MD_IFULL     3'h5
`define MD_SZERO     3'h6
`define MD_SFULL     3'h7
`define ST_RDY       0
`define ST_CAL       1
`define ST_ALL       2'h3
`endif

// [rtl/sdadc_pkg.sv]
// Types shared by the converter back end.
// Uses none of the macros in sdadc_cfg.svh.
`default_nettype none
package sdadc_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_CONV, PH_CAL} phase_t;

  typedef struct packed {
    logic [2:0]  sClk;
    logic [1:0]  sBit;
    logic [2:0]  mode;
    logic [2:0]  range;
    logic        bipolar;
    logic [3:0]  chan;
    logic [7:0]  word;
    logic [7:0]  wordAct;
    logic        wordPend;
    logic        wordSeen;
    logic [1:0]  settle;
    phase_t      phase;
    logic [23:0] data;
    logic [23:0] offset;
    logic [23:0] gain;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [7:0]  rdata;
    logic        restart;
    logic        refSel;
    logic [2:0]  pgaOut;
    logic        irq;
  } ctrl_t;

  typedef struct packed {
    logic [35:0] i1;
    logic [35:0] i2;
    logic [35:0] i3;
    logic [35:0] z1;
    logic [35:0] z2;
    logic [35:0] z3;
    logic [35:0] raw;
    logic [10:0] cnt;
    logic [7:0]  w;
    logic        valid;
  } dec_t;
endpackage
`default_nettype wire

// [rtl/sinc3_decimator.sv]
// Third-order sinc decimator for a one-bit modulator stream.
// Assumes sampleEn is a one-cycle strobe per modulator sample.
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_cfg.svh"
module sinc3_decimator #(
  parameter int W = 36
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          sampleEn,
  input  wire logic          bitIn,
  input  wire logic          restart,
  input  wire logic [7:0]    word,
  output logic      [W-1:0]  raw,
  output logic               rawValid
);
  generate
    if (W != 36) begin : g_bad
      $error("sinc3_decimator: W must be 36");
    end
  endgenerate

  sdadc_pkg::dec_t q;
  sdadc_pkg::dec_t n;
  logic [10:0] last;

  // Period is eight samples per word step
  assign last = (11'(q.w) << `DEC_SHIFT) - 11'h1;

  always_comb begin
    logic [35:0] d1;
    logic [35:0] d2;
    d1 = 36'h0;
    d2 = 36'h0;
    n = q;
    n.valid = 1'b0;
    if (restart) begin
      n = '0;
      n.w = word;
    end else if (sampleEn) begin
      n.i1 = q.i1 + 36'(bitIn);
      n.i2 = q.i2 + q.i1;
      n.i3 = q.i3 + q.i2;
      if (q.cnt == last) begin
        n.cnt = 11'h0;
        d1 = q.i3 - q.z1;
        d2 = d1 - q.z2;
        n.z1 = q.i3;
        n.z2 = d1;
        n.z3 = d2;
        n.raw = d2 - q.z3;
        n.valid = 1'b1;
      end else begin
        n.cnt = q.cnt + 11'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.w <= `WORD_RST;
    end else begin
      q <= n;
    end
  end

  assign raw = q.raw;
  assign rawValid = q.valid;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_cnt_bound;
    q.cnt <= last;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("sample count ran past the period");

  property p_valid_at_end;
    $rose(q.valid) |-> $past(q.cnt) == last && q.cnt == 11'h0;
  endproperty
  a_valid_at_end: assert property (p_valid_at_end)
    else $error("result not at end of period");
endmodule
`default_nettype wire

// [rtl/sdadc_filter_ctrl.sv]
// Sigma-delta converter back end with chopping off: filter word,
// settling, calibration, range select and register port.
// Assumes a 100 MHz core_clk; modulator clock and bit are async pins.
//
// What this block does
// - Filter word accepts only 3 to 255
// - Decimate by eight times filter word
// - One result per 8 x word samples
// - Filter word resets to 69
// - Sync change withholds results three periods
// - Unsynchronized steps keep results flowing
// - Each word step adds eight samples
// - Mode 110 starts system zero calibration
// - Mode 111 starts system full calibration
// - Bipolar zero calibration maps to mid-scale
// - Range field picks one of eight gains
// - Internal full calibration uses reference, unity
// - Ready flag blocks further result writes
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_cfg.svh"
module sdadc_filter_ctrl #(
  parameter int RAW_W = 36
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        modClk,
  input  wire logic        modBit,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  output logic      [2:0]  pgaRange,
  output logic             bipolarMode,
  output logic      [3:0]  chanSel,
  output logic             refCalSel,
  output logic             irq
);
  generate
    if (RAW_W != 36) begin : g_bad
      $error("sdadc_filter_ctrl: RAW_W must be 36");
    end
  endgenerate

  sdadc_pkg::ctrl_t q;
  sdadc_pkg::ctrl_t n;
  logic [RAW_W-1:0] rawSum;
  logic             rawValid;
  logic             sampleEn;
  logic [23:0]      raw24;
  logic             deliver;
  logic             syncChg;
  logic [1:0]       setSt;
  logic [1:0]       clrSt;

  function automatic logic [23:0] sub24(
    input logic [23:0] a,
    input logic [23:0] b
  );
    sub24 = a - b;
  endfunction

  function automatic logic [23:0] sat24(
    input logic [RAW_W-1:0] v
  );
    logic [RAW_W-1:0] s;
    s = v >> `RAW_SHIFT;
    if (|s[RAW_W-1:24]) begin
      sat24 = `SAT_CODE;
    end else begin
      sat24 = s[23:0];
    end
  endfunction

  // Rising edge of the resynchronised modulator clock
  assign sampleEn = q.sClk[1] & ~q.sClk[2];

  sinc3_decimator #(
    .W (RAW_W)
  ) u_dec (
    .core_clk (core_clk),
    .rst      (rst),
    .sampleEn (sampleEn),
    .bitIn    (q.sBit[1]),
    .restart  (q.restart),
    .word     (q.wordAct),
    .raw      (rawSum),
    .rawValid (rawValid)
  );

  assign raw24 = sat24(rawSum);
  // Settled output, no pending word, not just restarted
  assign deliver = rawValid && !q.restart
                && q.phase != sdadc_pkg::PH_IDLE
                && !q.wordPend && q.settle == 2'h0;

  always_comb begin
    n = q;
    n.restart = 1'b0;
    n.rdata = 8'h00;
    setSt = 2'b00;
    clrSt = 2'b00;
    syncChg = 1'b0;
    n.sClk = {q.sClk[1:0], modClk};
    n.sBit = {q.sBit[0], modBit};

    if (deliver) begin
      if (q.phase == sdadc_pkg::PH_CONV) begin
        // Unsynchronised input steps pass straight through
        if (!q.status[`ST_RDY]) begin
          n.data = sub24(raw24, q.offset);
        end
        setSt[`ST_RDY] = 1'b1;
        if (q.mode == `MD_SINGLE) begin
          n.mode = `MD_IDLE;
          n.phase = sdadc_pkg::PH_IDLE;
        end
      end else begin
        if (!q.status[`ST_RDY]) begin
          if (q.mode == `MD_IZERO || q.mode == `MD_SZERO) begin
            if (q.bipolar) begin
              n.offset = sub24(raw24, `MID_CODE);
            end else begin
              n.offset = raw24;
            end
          end else begin
            n.gain = sub24(raw24, q.offset);
          end
        end
        setSt = `ST_ALL;
        n.mode = `MD_IDLE;
        n.phase = sdadc_pkg::PH_IDLE;
      end
    end else if (rawValid && !q.restart
                 && q.phase != sdadc_pkg::PH_IDLE) begin
      if (q.wordPend) begin
        syncChg = 1'b1;
      end else if (q.settle != 2'h0) begin
        n.settle = q.settle - 2'h1;
      end
    end

    if (wr) begin
      case (addr)
        `A_MODE: begin
          n.mode = wdata[2:0];
          clrSt = `ST_ALL;
          // New command drops the old result's flags
          setSt = 2'b00;
          syncChg = 1'b1;
          if (n.mode == `MD_SINGLE || n.mode == `MD_CONT) begin
            n.phase = sdadc_pkg::PH_CONV;
          end else if (n.mode >= `MD_IZERO) begin
            n.phase = sdadc_pkg::PH_CAL;
          end else begin
            n.phase = sdadc_pkg::PH_IDLE;
          end
        end
        `A_CFG: begin
          n.range = wdata[2:0];
          n.bipolar = wdata[3];
          syncChg = q.phase != sdadc_pkg::PH_IDLE;
        end
        `A_CHAN: begin
          n.chan = wdata[3:0];
          syncChg = q.phase != sdadc_pkg::PH_IDLE;
        end
        `A_WORD: begin
          if (wdata >= `WORD_MIN) begin
            n.word = wdata;
            n.wordPend = 1'b1;
            n.wordSeen = 1'b1;
          end
        end
        `A_STAT: clrSt = wdata[1:0];
        `A_MASK: n.mask = wdata[1:0];
        default: ;
      endcase
    end

    // Restart the filter; drop the outputs before it settles
    if (syncChg) begin
      n.restart = 1'b1;
      n.settle = `SETTLE_CONV - 2'h1;
      n.wordAct = n.word;
      n.wordPend = 1'b0;
    end

    // Hardware set wins over a status-register clear in the same cycle
    n.status = (q.status & ~clrSt) | setSt;
    n.refSel = n.phase == sdadc_pkg::PH_CAL
            && n.mode == `MD_IFULL;
    n.pgaOut = n.refSel ? `UNITY_RANGE : n.range;
    n.irq = |(n.status & n.mask);

    if (rd) begin
      case (addr)
        `A_MODE:  n.rdata = {5'h00, q.mode};
        `A_CFG:   n.rdata = {4'h0, q.bipolar, q.range};
        `A_CHAN:  n.rdata = {4'h0, q.chan};
        `A_WORD:  n.rdata = q.word;
        `A_STAT:  n.rdata = {6'h00, q.status};
        `A_MASK:  n.rdata = {6'h00, q.mask};
        `A_DATA0: n.rdata = q.data[7:0];
        `A_DATA1: n.rdata = q.data[15:8];
        `A_DATA2: n.rdata = q.data[23:16];
        `A_OFS0:  n.rdata = q.offset[7:0];
        `A_OFS1:  n.rdata = q.offset[15:8];
        `A_OFS2:  n.rdata = q.offset[23:16];
        `A_GAIN0: n.rdata = q.gain[7:0];
        `A_GAIN1: n.rdata = q.gain[15:8];
        `A_GAIN2: n.rdata = q.gain[23:16];
        default:  n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.word <= `WORD_RST;
      q.wordAct <= `WORD_RST;
      q.mode <= `MD_OFF;
    end else begin
      q <= n;
    end
  end

  assign rdata = q.rdata;
  assign pgaRange = q.pgaOut;
  assign bipolarMode = q.bipolar;
  assign chanSel = q.chan;
  assign refCalSel = q.refSel;
  assign irq = q.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_word_range;
    q.word >= `WORD_MIN;
  endproperty
  a_word_range: assert property (p_word_range)
    else $error("filter word below legal minimum");

  property p_word_reset;
    !q.wordSeen |-> q.word == `WORD_RST && q.wordAct == `WORD_RST;
  endproperty
  a_word_reset: assert property (p_word_reset)
    else $error("filter word not at reset value");

  property p_restart_settle;
    q.restart |-> q.settle == `SETTLE_CONV - 2'h1
                  && q.wordAct == q.word && !q.wordPend;
  endproperty
  a_restart_settle: assert property (p_restart_settle)
    else $error("restart did not arm the settle count");

  property p_sys_zero;
    wr && addr == `A_MODE && wdata[2:0] == `MD_SZERO
      |=> q.phase == sdadc_pkg::PH_CAL && q.restart
          && q.status == 2'b00;
  endproperty
  a_sys_zero: assert property (p_sys_zero)
    else $error("system zero calibration not started");

  property p_sys_full;
    wr && addr == `A_MODE && wdata[2:0] == `MD_SFULL
      |=> q.phase == sdadc_pkg::PH_CAL && q.mode == `MD_SFULL
          && !q.refSel;
  endproperty
  a_sys_full: assert property (p_sys_full)
    else $error("system full calibration not started");

  property p_mid_scale;
    deliver && q.phase == sdadc_pkg::PH_CAL && q.bipolar
      && q.mode == `MD_SZERO && !q.status[`ST_RDY] && !wr
      |=> sub24($past(raw24), q.offset) == `MID_CODE;
  endproperty
  a_mid_scale: assert property (p_mid_scale)
    else $error("bipolar zero not at mid-scale");

  property p_range_out;
    !q.refSel |-> q.pgaOut == q.range;
  endproperty
  a_range_out: assert property (p_range_out)
    else $error("amplifier range not as programmed");

  property p_int_full;
    q.phase == sdadc_pkg::PH_CAL && q.mode == `MD_IFULL
      |-> q.refSel && q.pgaOut == `UNITY_RANGE;
  endproperty
  a_int_full: assert property (p_int_full)
    else $error("internal full calibration not at unity");

  property p_ready_hold;
    q.status[`ST_RDY] && !(wr && (addr == `A_STAT
      || addr == `A_MODE)) |=> $stable(q.data) && $stable(q.gain);
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("result written while ready set");

  property p_word_defer;
    wr && addr == `A_WORD && wdata >= `WORD_MIN && !rawValid
      && q.phase == sdadc_pkg::PH_CONV |=> $stable(q.wordAct);
  endproperty
  a_word_defer: assert property (p_word_defer)
    else $error("new word applied before period end");

  property p_mode_clear;
    wr && addr == `A_MODE |=> q.status == 2'b00 && q.restart;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("mode write did not clear the flags");

  property p_set_wins;
    deliver && !(wr && addr == `A_MODE) |=> q.status[`ST_RDY];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("ready not set by a finished result");

  property p_word_refuse;
    wr && addr == `A_WORD && wdata < `WORD_MIN |=> $stable(q.word);
  endproperty
  a_word_refuse: assert property (p_word_refuse)
    else $error("illegal filter word accepted");

  property p_cal_end;
    deliver && q.phase == sdadc_pkg::PH_CAL && !(wr && addr == `A_MODE)
      |=> q.status == `ST_ALL && q.mode == `MD_IDLE
          && q.phase == sdadc_pkg::PH_IDLE;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration did not finish cleanly");

  property p_irq_level;
    q.irq == |(q.status & q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt out of step with status");

  c_conv: cover property (deliver && q.phase == sdadc_pkg::PH_CONV);
  c_cal: cover property (deliver && q.phase == sdadc_pkg::PH_CAL);
  c_word: cover property (rawValid && q.wordPend && !q.restart);
  c_irq: cover property ($rose(q.irq));
endmodule
`default_nettype wire

// [sim/sdadc_mod_model.sv]
// Behavioural first-order modulator feeding the converter pins.
// Sample clock runs free and faster than the real one, to keep runs short.
`timescale 1ns/1ns
`default_nettype none
module sdadc_mod_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic [7:0] density,
  output logic            modClk,
  output logic            modBit
);
  logic [7:0] acc;
  initial begin
    modClk = 1'b0;
    modBit = 1'b0;
    acc = 8'h00;
    #3;
    forever begin
      #HALF_NS modClk = 1'b1;
      #HALF_NS modClk = 1'b0;
      // Bit changes away from the sampling edge
      {modBit, acc} = {1'b0, acc} + {1'b0, density};
    end
  end
endmodule
`default_nettype wire

// [sim/sdadc_filter_ctrl_tb.sv]
// Self-checking bench for the converter back end.
// Register port driven here; the modulator model feeds the pins.
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_cfg.svh"
module sdadc_filter_ctrl_tb;
  localparam int P = 20;
  localparam int LIMIT = 30000;
  localparam logic [7:0] WV [4] = '{8'h02, 8'h00, 8'hFF, 8'h03};
  localparam logic [7:0] WE [4] = '{8'h45, 8'h45, 8'hFF, 8'h03};
  logic       core_clk;
  logic       rst;
  wire logic  modClk;
  wire logic  modBit;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [2:0] pgaRange;
  logic       bipolarMode;
  logic [3:0] chanSel;
  logic       refCalSel;
  logic       irq;
  logic [7:0] density;
  int         errors;
  int         n_checks;
  int         seed;
  int         cyc;

  sdadc_filter_ctrl u_dut (
    .core_clk(core_clk), .rst(rst), .modClk(modClk), .modBit(modBit),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pgaRange(pgaRange), .bipolarMode(bipolarMode), .chanSel(chanSel),
    .refCalSel(refCalSel), .irq(irq)
  );
  sdadc_mod_model #(.HALF_NS(P*5)) u_mod (
    .density(density), .modClk(modClk), .modBit(modBit)
  );

  always #5 core_clk = ~core_clk;

  function automatic int per(input int w);
    return 8*w*P;
  endfunction
  // Sinc3 gain is the cube of the decimation
  function automatic logic [23:0] code(input int w, input int d);
    longint n;
    n = 8*w;
    return 24'((n*n*n*d/256) >> `RAW_SHIFT);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got,
               lo, hi);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [23:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = {16'h0, rdata};
  endtask
  task automatic r24(input logic [3:0] a, output logic [23:0] v);
    logic [23:0] b;
    for (int i = 0; i < 3; i++) begin
      rreg(a + 4'(i), b);
      v[8*i +: 8] = b[7:0];
    end
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (irq !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, irq, 1'b1);
    end
  endtask
  // Clears both status bits and lets the level output follow
  task automatic clr_stat();
    wreg(`A_STAT, 8'h03);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic cal(input logic [2:0] m);
    logic [23:0] v;
    int          n;
    clr_stat();
    wreg(`A_MASK, 8'h02);
    wreg(`A_MODE, {5'h0, m});
    wait_irq(n);
    chk_rng(n, 71*P, 73*P+10);
    rreg(`A_STAT, v);
    chk(v, 24'h3);
    rreg(`A_MODE, v);
    chk(v, {21'h0, `MD_IDLE});
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    logic [23:0] v;
    int          n;
    core_clk = 1'b0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    density = 8'h80;
    errors = 0;
    n_checks = 0;
    seed = 79152;
    cyc = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk({14'h0, pgaRange, bipolarMode, chanSel, refCalSel, irq}, 24'h0);
    rreg(`A_WORD, v);
    chk(v, 24'h45);
    for (int i = 0; i < 4; i++) begin
      wreg(`A_WORD, WV[i]);
      rreg(`A_WORD, v);
      chk(v, {16'h0, WE[i]});
    end
    wreg(4'hF, 8'hA5);
    rreg(4'hF, v);
    chk(v, 24'h0);
    $display("test reset and word done");
    for (int r = 0; r < 8; r++) begin
      v = 24'($random(seed));
      wreg(`A_CFG, {4'h0, v[0], 3'(r)});
      wreg(`A_CHAN, {4'h0, v[7:4]});
      #1 chk({16'h0, pgaRange, bipolarMode, chanSel},
             {16'h0, 3'(r), v[0], v[7:4]});
    end
    $display("test ranges done");
    wreg(`A_CFG, 8'h00);
    wreg(`A_MASK, 8'h01);
    wreg(`A_MODE, {5'h0, `MD_CONT});
    wait_irq(n);
    chk_rng(n, 71*P, 73*P+10);
    r24(`A_DATA0, v);
    chk(v, code(3, 8'h80));
    density <= 8'h40;
    repeat (2*per(3)) @(posedge core_clk);
    r24(`A_DATA0, v);
    chk(v, code(3, 8'h80));
    chk({23'h0, irq}, 24'h1);
    clr_stat();
    chk({23'h0, irq}, 24'h0);
    wait_irq(n);
    clr_stat();
    wait_irq(n);
    chk_rng(n+4, per(3)-4, per(3)+4);
    // Fourth result after the step is settled
    r24(`A_DATA0, v);
    chk(v, code(3, 8'h40));
    clr_stat();
    wreg(`A_WORD, 8'h04);
    wait_irq(n);
    chk_rng(n, 3*per(4), 3*per(4)+per(3)+10);
    clr_stat();
    wait_irq(n);
    chk_rng(n+4, per(4)-4, per(4)+4);
    $display("test conversion done");
    wreg(`A_MODE, {5'h0, `MD_OFF});
    wreg(`A_WORD, 8'h03);
    wreg(`A_CFG, 8'h08);
    density <= 8'h80;
    cal(`MD_SZERO);
    r24(`A_OFS0, v);
    chk(v, code(3, 8'h80) - `MID_CODE);
    clr_stat();
    wreg(`A_MASK, 8'h01);
    wreg(`A_MODE, {5'h0, `MD_SINGLE});
    wait_irq(n);
    r24(`A_DATA0, v);
    chk(v, `MID_CODE);
    cal(`MD_SFULL);
    r24(`A_GAIN0, v);
    chk(v, `MID_CODE);
    wreg(`A_CFG, 8'h0D);
    cal(`MD_IZERO);
    r24(`A_OFS0, v);
    chk(v, code(3, 8'h80) - `MID_CODE);
    clr_stat();
    wreg(`A_MODE, {5'h0, `MD_IFULL});
    repeat (5) @(posedge core_clk);
    #1 chk({20'h0, pgaRange, refCalSel}, {20'h0, `UNITY_RANGE, 1'b1});
    wait_irq(n);
    #1 chk({20'h0, pgaRange, refCalSel}, {20'h0, 3'h5, 1'b0});
    r24(`A_GAIN0, v);
    chk(v, `MID_CODE);
    $display("test calibration done");
    end_sim();
  end
endmodule
`default_nettype wire
